// ---- hdl/asf_ctrl.sv ----
// Auxiliary synthesizer control-word decode and fastlock pin/gain control
`timescale 1ns/100ps
module asf_ctrl
  import asf_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_word_vld,
  input  wire logic [WORD_W-1:0] i_word,
  input  wire logic              i_pd_event,
  output logic                   o_pump_high,
  output logic                   o_pump_tristate,
  output logic                   o_powerdown,
  output logic                   o_pd_async,
  output logic                   o_counter_clear,
  output logic                   o_presc_16,
  output logic      [SWAL_W-1:0] o_swallow,
  output logic      [MAIN_W-1:0] o_main,
  output logic      [DIV_W-1:0]  o_feedback_div,
  output logic                   o_main_illegal,
  output logic      [TOC_W-1:0]  o_active_toc,
  output logic                   o_fastlock_pin_o,
  output logic                   o_fastlock_pin_oe
);
  logic              aux_pump_gain_sel_r;
  logic              aux_pump_tristate_r;
  logic              aux_powerdown_r;
  logic              clear_r;
  logic              presc_r;
  logic [SWAL_W-1:0] swal_r;
  logic [MAIN_W-1:0] main_r;
  logic [TOC_W-1:0]  aux_fastlock_timeout;
  logic              auto_busy;
  logic              ld_ref;
  logic              ld_fb;
  logic              ld_fl;
  logic [ADDR_W-1:0] word_address_bits;
  asf_pin_e          pin_mode;
  logic              force_high;
  logic [DIV_W-1:0]  modulus;

  // ----------------------------------------
  // Word routing
  // ----------------------------------------
  assign word_address_bits = i_word[ADDR_W-1:0];
  // R17 route by address
  assign ld_ref = i_word_vld && (word_address_bits == ADDR_REF_PUMP);
  assign ld_fb  = i_word_vld && (word_address_bits == ADDR_FEEDBACK);
  assign ld_fl  = i_word_vld && (word_address_bits == ADDR_FASTLOCK);

  // ----------------------------------------
  // Reference and pump word
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aux_pump_gain_sel_r <= 1'b0;
      aux_pump_tristate_r <= 1'b0;
      clear_r             <= 1'b0;
    end else if (ld_ref) begin
      // R1 gain bit
      aux_pump_gain_sel_r <= i_word[BIT_GAIN];
      // R2 tri-state bit
      aux_pump_tristate_r <= i_word[BIT_TRI];
      // R5 counter clear
      clear_r             <= i_word[BIT_CLR];
    end
  end

  // ----------------------------------------
  // Feedback divider word
  // ----------------------------------------
  // Bit 21 is ignored here, so a stray one from the host is harmless
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aux_powerdown_r <= 1'b0;
      presc_r         <= 1'b0;
      swal_r          <= '0;
      main_r          <= MAIN_MIN;
    end else if (ld_fb) begin
      // R4 power-down bit
      aux_powerdown_r <= i_word[BIT_PD];
      // R9 prescaler select
      presc_r         <= i_word[BIT_PRESC];
      // R7 swallow field
      swal_r          <= i_word[SWAL_LSB +: SWAL_W];
      // R8 main field
      main_r          <= i_word[MAIN_LSB +: MAIN_W];
    end
  end

  // ----------------------------------------
  // Fastlock word and timer
  // ----------------------------------------
  // R10 time-out field
  assign aux_fastlock_timeout = i_word[TOC_LSB +: TOC_W];

  asf_fastlock_timer #(
    .TW           (TOC_W)
  ) u_timer (
    .i_clk_sys    (i_clk_sys),
    .i_rst        (i_rst),
    .i_pd_event   (i_pd_event),
    .i_load       (ld_fl),
    .i_timeout    (aux_fastlock_timeout),
    .o_active_toc (o_active_toc),
    .o_auto_busy  (auto_busy)
  );

  // ----------------------------------------
  // Pin and gain decode
  // ----------------------------------------
  always_comb begin
    pin_mode   = ASF_PIN_FLOAT;
    force_high = 1'b0;
    case (o_active_toc)
      // R11 disabled, float
      TOC_OFF: begin
        pin_mode = ASF_PIN_FLOAT;
      end
      // R12 manual fastlock
      TOC_MANUAL: begin
        pin_mode   = ASF_PIN_LOW;
        force_high = 1'b1;
      end
      // R13 general low
      TOC_GP_LOW: begin
        pin_mode = ASF_PIN_LOW;
      end
      // R14 general high
      TOC_GP_HIGH: begin
        pin_mode = ASF_PIN_HIGH;
      end
      // R15 automatic fastlock
      default: begin
        pin_mode   = auto_busy ? ASF_PIN_LOW : ASF_PIN_FLOAT;
        force_high = auto_busy;
      end
    endcase
  end

  // Tri-state and power-down act on state directly, with no event wait
  always_comb begin
    // R1 pump level
    o_pump_high       = aux_pump_gain_sel_r;
    // R15 drop to low after time-out only when auto mode, else gain bit unless manual forces high
    if (o_active_toc > TOC_GP_HIGH) begin
      o_pump_high = force_high;
    end else if (force_high) begin
      o_pump_high = 1'b1;
    end
    // R2 immediate tri-state
    o_pump_tristate   = aux_pump_tristate_r;
    // R4 power state
    o_powerdown       = aux_powerdown_r;
    // R3 async when tri-state also set
    o_pd_async        = aux_powerdown_r && aux_pump_tristate_r;
    // R5 hold counters reset
    o_counter_clear   = clear_r || aux_powerdown_r;
    o_fastlock_pin_o  = (pin_mode == ASF_PIN_HIGH);
    o_fastlock_pin_oe = (pin_mode != ASF_PIN_FLOAT);
  end

  // ----------------------------------------
  // Divider setting
  // ----------------------------------------
  assign modulus = presc_r ? MOD_HIGH : MOD_LOW;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_presc_16     <= 1'b0;
      o_swallow      <= '0;
      o_main         <= MAIN_MIN;
      o_feedback_div <= '0;
      o_main_illegal <= 1'b0;
    end else begin
      o_presc_16     <= presc_r;
      o_swallow      <= swal_r;
      o_main         <= main_r;
      // R18 main times modulus plus swallow
      o_feedback_div <= DIV_W'(DIV_W'(main_r) * modulus + DIV_W'(swal_r));
      // R8 flag forbidden main count
      o_main_illegal <= (main_r < MAIN_MIN);
    end
  end
endmodule

// ---- hdl/asf_pkg.sv ----
// Constants for the auxiliary synthesizer control-word decode and fastlock block
// Function
// R1 - Gain bit picks pump current: clear gives 1 mA, set gives 4 mA.
// R2 - Tri-state bit floats the pump output at once, no clock wait.
// R3 - Tri-state and power-down bits together pick synchronous or asynchronous power-down.
// R4 - Power-down bit 1 powers the synthesizer down, 0 keeps it active.
// R5 - Counter-clear bit holds all three counters reset; restart is aligned.
// R6 - Host always writes zero into bit 21 of the feedback word.
// R7 - Swallow count is bits 6 to 3, any value 0 to 15.
// R8 - Main count is bits 20 to 7; host programs only 3 to 16383.
// R9 - Prescaler select 0 gives 8/9, 1 gives 16/17.
// R10 - Fastlock time-out is bits 14 to 3 of its word, 0 to 4095.
// R11 - Time-out 0: pin floats, pump follows gain bit, no automatic fastlock.
// R12 - Time-out 1: pin low, pump forced high: manual fastlock.
// R13 - Time-out 2: pin driven low, pump follows gain bit.
// R14 - Time-out 3: pin driven high, pump follows gain bit.
// R15 - Time-out N of 4 or more: pin low, pump high for N events, then release.
// R16 - New time-out value is latched only at the next phase-detector event.
// R17 - Each 24-bit word is routed by its low three address bits.
// R18 - Feedback division equals main count times modulus plus swallow count.
package asf_pkg;
  localparam int WORD_W    = 24;
  localparam int ADDR_W    = 3;
  localparam int SWAL_W    = 4;
  localparam int MAIN_W    = 14;
  localparam int TOC_W     = 12;
  localparam int DIV_W     = 19;

  localparam logic [ADDR_W-1:0] ADDR_REF_PUMP = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_FEEDBACK = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_FASTLOCK = 3'h5;

  localparam int BIT_GAIN    = 19;
  localparam int BIT_TRI     = 20;
  localparam int BIT_CLR     = 21;
  localparam int BIT_PRESC   = 22;
  localparam int BIT_PD      = 23;
  localparam int SWAL_LSB    = 3;
  localparam int MAIN_LSB    = 7;
  localparam int TOC_LSB     = 3;

  localparam logic [TOC_W-1:0]  TOC_OFF      = 12'h000;
  localparam logic [TOC_W-1:0]  TOC_MANUAL   = 12'h001;
  localparam logic [TOC_W-1:0]  TOC_GP_LOW   = 12'h002;
  localparam logic [TOC_W-1:0]  TOC_GP_HIGH  = 12'h003;
  localparam logic [TOC_W-1:0]  TOC_ONE      = 12'h001;
  localparam logic [MAIN_W-1:0] MAIN_MIN     = 14'h0003;
  localparam logic [DIV_W-1:0]  MOD_LOW      = 19'h00008;
  localparam logic [DIV_W-1:0]  MOD_HIGH     = 19'h00010;

  typedef enum logic [1:0] {
    ASF_PIN_FLOAT,
    ASF_PIN_LOW,
    ASF_PIN_HIGH
  } asf_pin_e;
endpackage

// ---- hdl/asf_fastlock_timer.sv ----
// Fastlock time-out counter stepping on phase-detector events
`timescale 1ns/100ps
module asf_fastlock_timer
  import asf_pkg::*;
#(
  parameter int TW = TOC_W
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  input  wire logic          i_pd_event,
  input  wire logic          i_load,
  input  wire logic [TW-1:0] i_timeout,
  output logic      [TW-1:0] o_active_toc,
  output logic               o_auto_busy
);
  // Elaboration check: the decode compares against package codes of the field width
  if (TW != TOC_W) begin
    $error("asf_fastlock_timer: width must match field");
  end

  logic [TW-1:0] pend_r;
  logic          pend_vld_r;
  logic [TW-1:0] cnt_r;

  // ----------------------------------------
  // Pending value
  // ----------------------------------------
  // R16 hold until event
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pend_r     <= '0;
      pend_vld_r <= 1'b0;
    end else if (i_load) begin
      pend_r     <= i_timeout;
      pend_vld_r <= 1'b1;
    end else if (i_pd_event) begin
      pend_vld_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Active value and counter
  // ----------------------------------------
  // R16 latch at event; a write in the event cycle waits for the next one
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_active_toc <= '0;
    end else if (i_pd_event && pend_vld_r) begin
      o_active_toc <= pend_r;
    end
  end

  // R15 count N events
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_r <= '0;
    end else if (i_pd_event && pend_vld_r) begin
      cnt_r <= (pend_r > TOC_GP_HIGH) ? pend_r - TOC_ONE : '0;
    end else if (i_pd_event && cnt_r != '0) begin
      cnt_r <= cnt_r - TOC_ONE;
    end
  end

  // Busy from the latching event through N events
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_auto_busy <= 1'b0;
    end else if (i_pd_event && pend_vld_r) begin
      o_auto_busy <= (pend_r > TOC_GP_HIGH);
    end else if (i_pd_event && cnt_r == '0) begin
      o_auto_busy <= 1'b0;
    end
  end
endmodule

// ---- tb/asf_ctrl_sva.sv ----
// Checker for the auxiliary synthesizer control block
`timescale 1ns/100ps
module asf_ctrl_sva
  import asf_pkg::*;
(
  input wire logic              i_clk_sys,
  input wire logic              i_rst,
  input wire logic              i_word_vld,
  input wire logic [WORD_W-1:0] i_word,
  input wire logic              i_pd_event,
  input wire logic              o_pump_high,
  input wire logic              o_pump_tristate,
  input wire logic              o_powerdown,
  input wire logic              o_pd_async,
  input wire logic              o_counter_clear,
  input wire logic              o_presc_16,
  input wire logic [SWAL_W-1:0] o_swallow,
  input wire logic [MAIN_W-1:0] o_main,
  input wire logic [DIV_W-1:0]  o_feedback_div,
  input wire logic              o_main_illegal,
  input wire logic [TOC_W-1:0]  o_active_toc,
  input wire logic              o_fastlock_pin_o,
  input wire logic              o_fastlock_pin_oe
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire logic ref_wr = i_word_vld && i_word[2:0] == ADDR_REF_PUMP;
  wire logic fb_wr  = i_word_vld && i_word[2:0] == ADDR_FEEDBACK;
  // Automatic write, then the event that latches it
  sequence s_fl_wr;
    i_word_vld && i_word[2:0] == ADDR_FASTLOCK && i_word[14:3] > TOC_GP_HIGH;
  endsequence
  sequence s_fl_evt;
    !i_word_vld && i_pd_event;
  endsequence
  tri_follow_a: assert property (ref_wr |=> o_pump_tristate == $past(i_word[BIT_TRI]))
    else $error("tristate does not follow its bit");
  pd_follow_a: assert property (fb_wr |=> o_powerdown == $past(i_word[BIT_PD]))
    else $error("powerdown does not follow its bit");
  pd_mode_a: assert property (o_pd_async == (o_powerdown && o_pump_tristate))
    else $error("power-down mode wrong");
  clr_hold_a: assert property (ref_wr && i_word[BIT_CLR] |=> o_counter_clear)
    else $error("counters not held");
  fb_fields_a: assert property (fb_wr |=> ##1 o_swallow == $past(i_word[6:3], 2)
    && o_main == $past(i_word[20:7], 2) && o_presc_16 == $past(i_word[BIT_PRESC], 2))
    else $error("feedback fields wrong");
  div_calc_a: assert property (!$past(i_rst) |-> o_feedback_div ==
    o_main * (o_presc_16 ? MOD_HIGH : MOD_LOW) + o_swallow) else $error("division wrong");
  main_flag_a: assert property (!$past(i_rst) |-> o_main_illegal == (o_main < MAIN_MIN))
    else $error("illegal main flag wrong");
  toc_hold_a: assert property (!$past(i_rst) && !$past(i_pd_event)
    && !$past(i_pd_event, 2) |-> $stable(o_active_toc)) else $error("time-out moved early");
  pin_off_a: assert property (o_active_toc == TOC_OFF |-> !o_fastlock_pin_oe)
    else $error("pin driven while off");
  pin_low_a: assert property ((o_active_toc == TOC_MANUAL || o_active_toc == TOC_GP_LOW)
    |-> o_fastlock_pin_oe && !o_fastlock_pin_o) else $error("pin not low");
  manual_pump_a: assert property (o_active_toc == TOC_MANUAL |-> o_pump_high)
    else $error("manual pump not high");
  pin_high_a: assert property (o_active_toc == TOC_GP_HIGH
    |-> o_fastlock_pin_oe && o_fastlock_pin_o) else $error("pin not high");
  auto_start_a: assert property (s_fl_wr ##1 s_fl_evt |=> o_fastlock_pin_oe
    && !o_fastlock_pin_o && o_pump_high && o_active_toc == $past(i_word[14:3], 2))
    else $error("automatic fastlock did not start");
endmodule
bind asf_ctrl asf_ctrl_sva u_sva (.i_clk_sys, .i_rst, .i_word_vld, .i_word, .i_pd_event,
  .o_pump_high, .o_pump_tristate, .o_powerdown, .o_pd_async, .o_counter_clear, .o_presc_16,
  .o_swallow, .o_main, .o_feedback_div, .o_main_illegal, .o_active_toc, .o_fastlock_pin_o,
  .o_fastlock_pin_oe);

// ---- tb/asf_host_model.sv ----
// Host model that writes whole control words into the block
`timescale 1ns/100ps
module asf_host_model
  import asf_pkg::*;
(
  input  wire logic              i_clk_sys,
  output logic                   o_word_vld,
  output logic      [WORD_W-1:0] o_word
);
  initial begin
    o_word_vld = 1'b0;
    o_word     = 24'h000000;
  end
  task automatic send(input logic [ADDR_W-1:0] addr, input logic [20:0] data);
    logic [20:0] d;
    d = data;
    if (addr == ADDR_FEEDBACK) d[18] = 1'b0;
    @(posedge i_clk_sys);
    #1;
    o_word_vld = 1'b1;
    o_word = {d, addr};
    @(posedge i_clk_sys);
    #1;
    o_word_vld = 1'b0;
    // Inverted so a stale word never looks valid
    o_word = ~o_word;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the auxiliary synthesizer control block
`timescale 1ns/100ps
module tb_top;
  import asf_pkg::*;
  logic i_clk_sys, i_rst, i_word_vld, i_pd_event;
  logic [WORD_W-1:0] i_word;
  logic o_pump_high, o_pump_tristate, o_powerdown, o_pd_async, o_counter_clear;
  logic o_presc_16, o_main_illegal, o_fastlock_pin_o, o_fastlock_pin_oe;
  logic [SWAL_W-1:0] o_swallow;
  logic [MAIN_W-1:0] o_main;
  logic [DIV_W-1:0]  o_feedback_div;
  logic [TOC_W-1:0]  o_active_toc;
  int mismatches = 0, check_count = 0;
  logic [MAIN_W-1:0] mains[3] = '{14'h0003, 14'h3FFF, 14'h0002};
  logic [SWAL_W-1:0] swals[3] = '{4'h0, 4'hF, 4'h5};
  asf_ctrl DUT (.i_clk_sys, .i_rst, .i_word_vld, .i_word, .i_pd_event, .o_pump_high,
    .o_pump_tristate, .o_powerdown, .o_pd_async, .o_counter_clear, .o_presc_16, .o_swallow,
    .o_main, .o_feedback_div, .o_main_illegal, .o_active_toc, .o_fastlock_pin_o,
    .o_fastlock_pin_oe);
  asf_host_model host (.i_clk_sys, .o_word_vld(i_word_vld), .o_word(i_word));
  task automatic check(input string name, input logic [DIV_W-1:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic pd_pulse();
    i_pd_event = 1'b1;
    tick(1);
    i_pd_event = 1'b0;
  endtask
  task automatic pump_wr(input logic g, t, c);
    host.send(ADDR_REF_PUMP, {2'b00, c, t, g, 16'h000A});
    tick(2);
  endtask
  task automatic fb_wr(input logic p, s, input logic [MAIN_W-1:0] m, input logic [SWAL_W-1:0] a);
    host.send(ADDR_FEEDBACK, {p, s, 1'b0, m, a});
    tick(2);
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    mismatches++;
    end_sim();
  end
  initial begin
    i_rst = 1'b1;
    i_pd_event = 1'b0;
    tick(4);
    i_rst = 1'b0;
    tick(1);
    check("main_rst", o_main, MAIN_MIN);
    check("pin_oe_rst", o_fastlock_pin_oe, 1'b0);
    for (int i = 0; i < 8; i++) begin
      pump_wr(1'b0, i[0], i[2]);
      fb_wr(i[1], 1'b0, MAIN_MIN, 4'h0);
      check("tristate", o_pump_tristate, i[0]);
      check("powerdown", o_powerdown, i[1]);
      check("pd_async", o_pd_async, i[0] & i[1]);
      check("cnt_clear", o_counter_clear, i[2] | i[1]);
    end
    for (int i = 0; i < 3; i++) begin
      fb_wr(1'b0, i[0], mains[i], swals[i]);
      check("presc", o_presc_16, i[0]);
      check("swallow", o_swallow, swals[i]);
      check("main", o_main, mains[i]);
      check("illegal", o_main_illegal, mains[i] < 3);
      check("div", o_feedback_div, mains[i] * (i[0] ? 19'h10 : 19'h08) + swals[i]);
    end
    pump_wr(1'b0, 1'b0, 1'b0);
    for (int a = 0; a < 8; a++) begin
      if (a < 3 || a > 5) begin
        host.send(ADDR_W'(a), 21'h1FFFFF);
        pd_pulse();
        tick(1);
        check("tri_unmapped", o_pump_tristate, 1'b0);
        check("pd_unmapped", o_powerdown, 1'b0);
        check("toc_unmapped", o_active_toc, TOC_OFF);
      end
    end
    for (int g = 0; g < 2; g++) begin
      pump_wr(g[0], 1'b0, 1'b0);
      for (int t = 0; t < 4; t++) begin
        host.send(ADDR_FASTLOCK, {9'h000, TOC_W'(t)});
        pd_pulse();
        tick(1);
        check("toc", o_active_toc, t);
        check("pin_oe", o_fastlock_pin_oe, t != 0);
        if (t != 0) check("pin_o", o_fastlock_pin_o, t == 3);
        check("pump", o_pump_high, t == 1 || g == 1);
      end
    end
    // Gain bit left high so the drop to 1 mA is visible
    host.send(ADDR_FASTLOCK, {9'h000, 12'h005});
    // Latching event plus N further events before the pin is released
    for (int k = 1; k <= 6; k++) begin
      pd_pulse();
      tick(1);
      check("auto_oe", o_fastlock_pin_oe, k < 6);
      check("auto_pump", o_pump_high, k < 6);
    end
    host.send(ADDR_FASTLOCK, {9'h000, TOC_GP_HIGH});
    tick(3);
    check("toc_wait", o_active_toc, 12'h005);
    pd_pulse();
    tick(1);
    check("toc_new", o_active_toc, TOC_GP_HIGH);
    end_sim();
  end
endmodule
